// ---- rtl/phy_firmware_offset_regs.sv ----
/*
 Register bank holding firmware fetch setup for four integrated PHY
 macros, on a plain word-addressed port with read data one cycle later.
 Assumes the management master and the PHY fetch logic share clk_in.
*/
// The implementer's own choice: strobed register access.
`default_nettype none
module phy_firmware_offset_regs (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [phy_fw_pkg::ADDR_W-1:0] addr_in,
    input wire logic [phy_fw_pkg::DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [phy_fw_pkg::DATA_W-1:0] rdata_out,
    output var phy_fw_pkg::phy_fw_cfg_t [phy_fw_pkg::NUM_PHYS-1:0] phy_cfg_out
);
    import phy_fw_pkg::*;

    logic [NUM_PHYS-1:0] sel;
    logic [DATA_W-1:0] value [NUM_PHYS];
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] nxt_rdata;

    fw_addr_decode u_decode (
        .addr_in(addr_in),
        .sel_out(sel)
    );

    // All four share one reset value; each of the four is fixed to it
    for (genvar i = 0; i < NUM_PHYS; i++) begin : g_reg
        fw_offset_reg u_reg (
            .clk_in(clk_in),
            .resetn_in(resetn_in),
            .wr_in(wr_in & sel[i]),
            .wdata_in(wdata_in),
            .value_out(value[i]),
            .cfg_out(phy_cfg_out[i])
        );
    end

    // Unmapped reads return zero; data is valid only the cycle after
    always_comb begin
        nxt_rdata = ZERO_DATA;
        if (rd_in) begin
            for (int i = 0; i < NUM_PHYS; i++) begin
                if (sel[i]) begin
                    nxt_rdata = value[i];
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            rdata_ff <= ZERO_DATA;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign rdata_out = rdata_ff;

    // One write strobe to a register, then a read strobe of it
    sequence s_write_phy1;
        wr_in && sel[1];
    endsequence

    sequence s_read_phy1;
        rd_in && sel[1] && !wr_in;
    endsequence

    a_write_readback: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        s_write_phy1 ##1 s_read_phy1
        |=> rdata_out == $past(wdata_in, 2))
        else $error("readback differs from written value");

    a_src_select: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        wr_in && sel[0] |=> phy_cfg_out[0].external_eeprom_source
            == $past(wdata_in[SRC_BIT]))
        else $error("source select not following bit 15");

    a_invert_bit: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        wr_in && sel[2] |=> phy_cfg_out[2].firmware_address_invert
            == $past(wdata_in[INV_BIT]))
        else $error("invert not following bit 14");

    a_base_addr: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        wr_in && sel[3] |=> phy_cfg_out[3].firmware_base
            == {$past(wdata_in[OFFS_MSB:0]), LOW_ZERO})
        else $error("firmware base not formed from offset");

    a_low_zero: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        phy_cfg_out[1].firmware_base[LOW_ZERO_W-1:0] == LOW_ZERO)
        else $error("low offset bits not zero");

    a_reset_value: assert property (@(posedge clk_in)
        !resetn_in |=> value[0] == FW_RESET
            && phy_cfg_out[0].firmware_address_invert
            && !phy_cfg_out[0].external_eeprom_source)
        else $error("first register reset value wrong");

    a_hold_value: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        !(wr_in && sel[2]) |=> $stable(value[2]))
        else $error("register changed without a write");

    a_word_decode: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        rd_in && sel == '0 |=> rdata_out == ZERO_DATA)
        else $error("unmapped read not zero");

    a_cfg_matches: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        phy_cfg_out[1].firmware_base[BASE_W-1:LOW_ZERO_W]
            == value[1][OFFS_MSB:0])
        else $error("second PHY cfg out of step");

    // Remaining PHYs: same field mapping as the checks above
    a_src_select_1: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        wr_in && sel[1] |=> phy_cfg_out[1].external_eeprom_source
            == $past(wdata_in[SRC_BIT]))
        else $error("source select 1 not following bit 15");

    a_src_select_2: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        wr_in && sel[2] |=> phy_cfg_out[2].external_eeprom_source
            == $past(wdata_in[SRC_BIT]))
        else $error("source select 2 not following bit 15");

    a_src_select_3: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        wr_in && sel[3] |=> phy_cfg_out[3].external_eeprom_source
            == $past(wdata_in[SRC_BIT]))
        else $error("source select 3 not following bit 15");

    // Inversion is only passed on; the fetch unit applies it for the internal source only
    a_invert_bit_0: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        wr_in && sel[0] |=> phy_cfg_out[0].firmware_address_invert
            == $past(wdata_in[INV_BIT]))
        else $error("invert 0 not following bit 14");

    a_invert_bit_1: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        wr_in && sel[1] |=> phy_cfg_out[1].firmware_address_invert
            == $past(wdata_in[INV_BIT]))
        else $error("invert 1 not following bit 14");

    a_invert_bit_3: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        wr_in && sel[3] |=> phy_cfg_out[3].firmware_address_invert
            == $past(wdata_in[INV_BIT]))
        else $error("invert 3 not following bit 14");

    a_base_addr_0: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        wr_in && sel[0] |=> phy_cfg_out[0].firmware_base
            == {$past(wdata_in[OFFS_MSB:0]), LOW_ZERO})
        else $error("firmware base 0 not formed from offset");

    a_base_addr_1: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        wr_in && sel[1] |=> phy_cfg_out[1].firmware_base
            == {$past(wdata_in[OFFS_MSB:0]), LOW_ZERO})
        else $error("firmware base 1 not formed from offset");

    a_base_addr_2: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        wr_in && sel[2] |=> phy_cfg_out[2].firmware_base
            == {$past(wdata_in[OFFS_MSB:0]), LOW_ZERO})
        else $error("firmware base 2 not formed from offset");

    // Fetch units rely on 16-byte alignment of the base
    a_low_zero_0: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        phy_cfg_out[0].firmware_base[LOW_ZERO_W-1:0] == LOW_ZERO)
        else $error("low offset bits 0 not zero");

    a_low_zero_2: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        phy_cfg_out[2].firmware_base[LOW_ZERO_W-1:0] == LOW_ZERO)
        else $error("low offset bits 2 not zero");

    a_low_zero_3: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        phy_cfg_out[3].firmware_base[LOW_ZERO_W-1:0] == LOW_ZERO)
        else $error("low offset bits 3 not zero");

    // A stray change here would move a live PHY's code fetch
    a_hold_value_0: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        !(wr_in && sel[0]) |=> $stable(value[0]))
        else $error("register 0 changed without a write");

    a_hold_value_1: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        !(wr_in && sel[1]) |=> $stable(value[1]))
        else $error("register 1 changed without a write");

    a_hold_value_3: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        !(wr_in && sel[3]) |=> $stable(value[3]))
        else $error("register 3 changed without a write");

    a_reset_value_1: assert property (@(posedge clk_in)
        !resetn_in |=> value[1] == FW_RESET
            && phy_cfg_out[1].firmware_address_invert
            && !phy_cfg_out[1].external_eeprom_source)
        else $error("second register reset value wrong");

    a_reset_value_2: assert property (@(posedge clk_in)
        !resetn_in |=> value[2] == FW_RESET
            && phy_cfg_out[2].firmware_address_invert
            && !phy_cfg_out[2].external_eeprom_source)
        else $error("third register reset value wrong");

    a_reset_value_3: assert property (@(posedge clk_in)
        !resetn_in |=> value[3] == FW_RESET
            && phy_cfg_out[3].firmware_address_invert
            && !phy_cfg_out[3].external_eeprom_source)
        else $error("fourth register reset value wrong");

    // Read right after write must see the new word
    sequence s_write_phy0;
        wr_in && sel[0];
    endsequence

    sequence s_read_phy0;
        rd_in && sel[0] && !wr_in;
    endsequence

    a_readback_phy0: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        s_write_phy0 ##1 s_read_phy0
        |=> rdata_out == $past(wdata_in, 2))
        else $error("readback 0 differs from written value");

    sequence s_write_phy2;
        wr_in && sel[2];
    endsequence

    sequence s_read_phy2;
        rd_in && sel[2] && !wr_in;
    endsequence

    a_readback_phy2: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        s_write_phy2 ##1 s_read_phy2
        |=> rdata_out == $past(wdata_in, 2))
        else $error("readback 2 differs from written value");

    sequence s_write_phy3;
        wr_in && sel[3];
    endsequence

    sequence s_read_phy3;
        rd_in && sel[3] && !wr_in;
    endsequence

    a_readback_phy3: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        s_write_phy3 ##1 s_read_phy3
        |=> rdata_out == $past(wdata_in, 2))
        else $error("readback 3 differs from written value");

    // Read data stands one cycle only, zero otherwise
    a_read_idle: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        !rd_in |=> rdata_out == ZERO_DATA)
        else $error("read data present without a read");

    // Unmapped words must leave every register alone
    a_unmapped_write: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        wr_in && sel == '0 |=> $stable(value[0]) && $stable(value[1])
            && $stable(value[2]) && $stable(value[3]))
        else $error("unmapped write changed a register");

    a_sel_onehot: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        $onehot0(sel))
        else $error("more than one register selected");
endmodule // phy_firmware_offset_regs
`default_nettype wire

// ---- rtl/phy_fw_pkg.sv ----
/*
 Package for the PHY firmware offset register bank: word addresses,
 field positions, reset values and the carrier struct for each PHY.
 Assumes a 16-bit word-addressed register port.
*/
`default_nettype none
package phy_fw_pkg;
    localparam int NUM_PHYS = 4;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int OFFS_W = 14;
    localparam int BASE_W = 18;
    localparam int LOW_ZERO_W = 4;
    localparam int SRC_BIT = 15;
    localparam int INV_BIT = 14;
    localparam int OFFS_MSB = 13;
    localparam logic [ADDR_W-1:0] PHY0_FW_ADDR = 16'hF700;
    localparam logic [ADDR_W-1:0] PHY1_FW_ADDR = 16'hF710;
    localparam logic [ADDR_W-1:0] PHY2_FW_ADDR = 16'hF720;
    localparam logic [ADDR_W-1:0] PHY3_FW_ADDR = 16'hF730;
    localparam logic [DATA_W-1:0] FW_RESET = 16'h4000;
    localparam logic [DATA_W-1:0] ZERO_DATA = 16'h0000;
    localparam logic [LOW_ZERO_W-1:0] LOW_ZERO = 4'h0;

    typedef struct packed {
        logic external_eeprom_source;
        logic firmware_address_invert;
        logic [BASE_W-1:0] firmware_base;
    } phy_fw_cfg_t;
endpackage
`default_nettype wire

// ---- rtl/fw_addr_decode.sv ----
/*
 Word address decoder: one-hot select of the four firmware registers.
 Assumes the address is a word address from the same clock domain.
*/
`default_nettype none
module fw_addr_decode (
    input wire logic [phy_fw_pkg::ADDR_W-1:0] addr_in,
    output logic [phy_fw_pkg::NUM_PHYS-1:0] sel_out
);
    import phy_fw_pkg::*;
    always_comb begin
        sel_out[0] = (addr_in == PHY0_FW_ADDR);
        sel_out[1] = (addr_in == PHY1_FW_ADDR);
        sel_out[2] = (addr_in == PHY2_FW_ADDR);
        sel_out[3] = (addr_in == PHY3_FW_ADDR);
    end
endmodule // fw_addr_decode
`default_nettype wire

// ---- rtl/fw_offset_reg.sv ----
/*
 One firmware offset register and its derived PHY configuration.
 Assumes a synchronous active-low reset and same-clock write strobe.
*/
`default_nettype none
module fw_offset_reg (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic wr_in,
    input wire logic [phy_fw_pkg::DATA_W-1:0] wdata_in,
    output logic [phy_fw_pkg::DATA_W-1:0] value_out,
    output var phy_fw_pkg::phy_fw_cfg_t cfg_out
);
    import phy_fw_pkg::*;
    logic [DATA_W-1:0] value_ff;
    logic [DATA_W-1:0] nxt_value;
    phy_fw_cfg_t cfg_ff;
    phy_fw_cfg_t nxt_cfg;

    always_comb begin
        nxt_value = wr_in ? wdata_in : value_ff;
        nxt_cfg.external_eeprom_source = nxt_value[SRC_BIT];
        nxt_cfg.firmware_address_invert = nxt_value[INV_BIT];
        nxt_cfg.firmware_base = {nxt_value[OFFS_MSB:0], LOW_ZERO};
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            value_ff <= FW_RESET;
            // Derived from the reset word so the two can never disagree
            cfg_ff <= '{FW_RESET[SRC_BIT], FW_RESET[INV_BIT],
                {FW_RESET[OFFS_MSB:0], LOW_ZERO}};
        end else begin
            value_ff <= nxt_value;
            cfg_ff <= nxt_cfg;
        end
    end

    assign value_out = value_ff;
    assign cfg_out = cfg_ff;
endmodule // fw_offset_reg
`default_nettype wire

// ---- bench/phy_fetch_model.sv ----
/* Model of one PHY firmware fetch unit: forms its first fetch address.
 Assumes the bank's configuration struct, held steady between writes. */
`default_nettype none
module phy_fetch_model (
    input wire phy_fw_pkg::phy_fw_cfg_t cfg_in,
    output logic [phy_fw_pkg::BASE_W-1:0] fetch_addr_out,
    output logic use_eeprom_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import phy_fw_pkg::*;
    assign use_eeprom_out = cfg_in.external_eeprom_source;
    // Inversion ignored for the external source
    assign fetch_addr_out = (cfg_in.firmware_address_invert &&
        !cfg_in.external_eeprom_source) ? ~cfg_in.firmware_base :
        cfg_in.firmware_base;
endmodule // phy_fetch_model
`default_nettype wire

// ---- bench/phy_firmware_offset_regs_tb_top.sv ----
/* Self-checking bench for the firmware offset bank and four fetch models.
 Assumes the package and design files are compiled first. */
`default_nettype none
module phy_firmware_offset_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import phy_fw_pkg::*;
    logic clk_in = 1'b0, resetn_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
    logic [15:0] addr_in = 16'h0000, wdata_in = 16'h0000, rdata_out;
    phy_fw_cfg_t [NUM_PHYS-1:0] phy_cfg_out;
    logic [BASE_W-1:0] fetch [NUM_PHYS];
    logic ext [NUM_PHYS];
    int errors = 0, n_tests = 0, cycles = 0;
    logic [15:0] map [NUM_PHYS] = '{PHY0_FW_ADDR, PHY1_FW_ADDR,
        PHY2_FW_ADDR, PHY3_FW_ADDR};
    // Each value hits a different source and inversion pairing
    logic [15:0] vals [NUM_PHYS] = '{16'hC123, 16'h4ABC, 16'h8001, 16'h3FFF};
    phy_firmware_offset_regs dut (.clk_in(clk_in), .resetn_in(resetn_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out), .phy_cfg_out(phy_cfg_out));
    for (genvar g = 0; g < NUM_PHYS; g++) begin : phy
        phy_fetch_model model (.cfg_in(phy_cfg_out[g]),
            .fetch_addr_out(fetch[g]), .use_eeprom_out(ext[g]));
    end
    always #5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            results();
        end
    end
    task automatic check(string what, logic [19:0] seen, logic [19:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [15:0] a, logic [15:0] d);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic rd(logic [15:0] a, logic [15:0] exp);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 check("rdata", {4'h0, rdata_out}, {4'h0, exp});
        @(posedge clk_in);
    endtask
    task automatic cfg(int i, logic [15:0] v);
        logic [17:0] b;
        b = {v[13:0], 4'h0};
        check("cfg", phy_cfg_out[i], {v[15:14], b});
        check("eeprom", {19'h0, ext[i]}, {19'h0, v[15]});
        check("fetch", {2'h0, fetch[i]},
            {2'h0, (v[14] && !v[15]) ? ~b : b});
    endtask
    task automatic test_reset();
        for (int i = 0; i < NUM_PHYS; i++) begin
            rd(map[i], FW_RESET);
            cfg(i, FW_RESET);
        end
        $display("test reset done");
    endtask
    task automatic test_write();
        for (int i = 0; i < NUM_PHYS; i++) wr(map[i], vals[i]);
        for (int i = 0; i < NUM_PHYS; i++) begin
            rd(map[i], vals[i]);
            cfg(i, vals[i]);
        end
        $display("test write done");
    endtask
    task automatic test_unmapped();
        // Word addressing: F701 is not a byte lane of F700
        wr(16'hF701, 16'hFFFF);
        rd(16'hF701, 16'h0000);
        rd(map[0], vals[0]);
        $display("test unmapped done");
    endtask
    task automatic test_back2back();
        for (int i = 0; i < NUM_PHYS; i++) begin
            logic [15:0] v;
            v = vals[NUM_PHYS-1-i];
            addr_in <= map[i];
            wdata_in <= v;
            wr_in <= 1'b1;
            @(posedge clk_in);
            wr_in <= 1'b0;
            rd_in <= 1'b1;
            @(posedge clk_in);
            rd_in <= 1'b0;
            #1 check("b2b", {4'h0, rdata_out}, {4'h0, v});
            cfg(i, v);
            @(posedge clk_in);
        end
        $display("test back to back done");
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk_in);
        resetn_in <= 1'b1;
        @(posedge clk_in);
        test_reset();
        test_write();
        test_unmapped();
        test_back2back();
        results();
    end
endmodule // phy_firmware_offset_regs_tb_top
`default_nettype wire
